// File: xrm_pkg.sv
// Shared constants for the reconfiguration manager and the reconfiguration controller.
`default_nettype none
package xrm_pkg;
   // ===========================================================
   // Controller word addresses on the management link
   localparam logic [6:0] XRM_A_LCH = 7'h08;
   localparam logic [6:0] XRM_A_SCTL = 7'h38;
   localparam logic [6:0] XRM_A_CSR = 7'h3A;
   localparam logic [6:0] XRM_A_OFF = 7'h3B;
   localparam logic [6:0] XRM_A_DATA = 7'h3C;
   // ===========================================================
   // Control/status register fields and streamer modes
   localparam int XRM_CSR_WR = 0;
   localparam int XRM_CSR_RD = 1;
   localparam int XRM_CSR_BUSY = 8;
   localparam logic [1:0] XRM_MODE_MIF = 2'h0;
   localparam logic [1:0] XRM_MODE_MAN = 2'h1;
   // ===========================================================
   // Logical channels and request table
   localparam int XRM_NIF = 5;
   localparam int XRM_NREQ = 3;
   localparam int XRM_NSTEP = 2;
   localparam int XRM_NXREG = 16;
   localparam logic [9:0] XRM_LCN_DU_RX = 10'h000;
   localparam logic [9:0] XRM_LCN_RX = 10'h002;
   localparam logic [9:0] XRM_LCN_TX_PLL = 10'h004;
   localparam logic [9:0] XRM_REQ_LCN [XRM_NREQ] = '{XRM_LCN_DU_RX, XRM_LCN_RX, XRM_LCN_TX_PLL};
   localparam logic [31:0] XRM_STEP_OFF [XRM_NREQ][XRM_NSTEP] = '{
      '{32'h0000_0002, 32'h0000_0005}, '{32'h0000_0002, 32'h0000_0005},
      '{32'h0000_0009, 32'h0000_000C}};
   localparam logic [31:0] XRM_STEP_MASK [XRM_NREQ][XRM_NSTEP] = '{
      '{32'h0000_00F0, 32'h0000_0003}, '{32'h0000_00F0, 32'h0000_0003},
      '{32'h0000_0001, 32'h0000_0F00}};
   localparam logic [31:0] XRM_STEP_VAL0 [XRM_NREQ][XRM_NSTEP] = '{
      '{32'h0000_0010, 32'h0000_0001}, '{32'h0000_0010, 32'h0000_0001},
      '{32'h0000_0000, 32'h0000_0300}};
   localparam logic [31:0] XRM_STEP_VAL1 [XRM_NREQ][XRM_NSTEP] = '{
      '{32'h0000_00A0, 32'h0000_0002}, '{32'h0000_00A0, 32'h0000_0002},
      '{32'h0000_0001, 32'h0000_0500}};
   // ===========================================================
   // Manager registers on APB
   localparam logic [11:0] XRM_R_CTRL = 12'h000;
   localparam logic [11:0] XRM_R_STATUS = 12'h004;
   localparam logic [11:0] XRM_R_LASTWR = 12'h008;
   localparam logic [11:0] XRM_R_DONECNT = 12'h00C;
   localparam int XRM_CTRL_EN_BIT = 0;
   localparam int XRM_CTRL_SW_LSB = 1;
   localparam logic XRM_CTRL_EN_RST = 1'b1;
   localparam int XRM_ST_BUSY_BIT = 0;
   localparam int XRM_ST_PEND_LSB = 4;
   localparam int XRM_ST_STATE_LSB = 8;
   localparam int XRM_ST_CUR_LSB = 12;
   // ===========================================================
   // Timing
   localparam int XRM_CLK_NS = 8;
   localparam int XRM_BUSY_NS = 40;
   localparam int XRM_BUSY_CYC = (XRM_BUSY_NS + XRM_CLK_NS - 1) / XRM_CLK_NS;
endpackage : xrm_pkg
`default_nettype wire

// File: xrm_mgmt_if.sv
// Memory-mapped management link between the manager and the reconfiguration controller.
`timescale 1ns/1ps
`default_nettype none
interface xrm_mgmt_if (
   input wire logic pclk,
   input wire logic presetn
);
   logic [6:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   modport mgr (
      input pclk, presetn, readdata, waitrequest,
      output address, read, write, writedata
   );
   modport ctrl (
      input pclk, presetn, address, read, write, writedata,
      output readdata, waitrequest
   );
endinterface : xrm_mgmt_if
`default_nettype wire

// File: xrm_ctrl.sv
// Transceiver reconfiguration controller end: registers, streamer and transceiver register store.
`timescale 1ns/1ps
`default_nettype none
module xrm_ctrl (
   // Management link
   xrm_mgmt_if.ctrl m,
   // Observation
   output logic xcvr_busy,
   input wire logic [2:0] peek_lch,
   input wire logic [3:0] peek_off,
   output logic [31:0] peek_data
);
   // ===========================================================
   // Declarations
   localparam int MIF_LEN = 4;
   localparam logic [31:0] MIF_WORDS [MIF_LEN] = '{32'h0000_1111, 32'h0000_2222,
      32'h0000_3333, 32'h0000_4444};
   logic [31:0] xreg_r [xrm_pkg::XRM_NIF][xrm_pkg::XRM_NXREG];
   logic [9:0] lch_r;
   logic [1:0] mode_r;
   logic [31:0] off_r;
   logic [31:0] data_r;
   logic busy_r;
   logic [1:0] op_r;
   logic [3:0] cnt_r;
   logic [1:0] mif_idx_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic acc;
   logic wr_take;
   logic lch_ok;
   logic [2:0] li;
   logic [3:0] oi;

   assign acc = m.read | m.write;
   // One wait state per access so read data can come from a flop.
   assign m.waitrequest = acc & ~ack_r;
   assign m.readdata = rdata_r;
   assign wr_take = m.write & ack_r;
   assign li = lch_r[2:0];
   assign oi = off_r[3:0];
   assign lch_ok = (lch_r < 10'(xrm_pkg::XRM_NIF));
   assign xcvr_busy = busy_r;

   always_ff @(posedge m.pclk or negedge m.presetn) begin
      if (!m.presetn) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc & ~ack_r;
         if (m.read && !ack_r) begin
            case (m.address)
               xrm_pkg::XRM_A_LCH: rdata_r <= {22'h0, lch_r};
               xrm_pkg::XRM_A_SCTL: rdata_r <= {30'h0, mode_r};
               xrm_pkg::XRM_A_CSR: rdata_r <= 32'(busy_r) << xrm_pkg::XRM_CSR_BUSY;
               xrm_pkg::XRM_A_OFF: rdata_r <= off_r;
               xrm_pkg::XRM_A_DATA: rdata_r <= data_r;
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ===========================================================
   // Registers, streamer and busy sequencing
   always_ff @(posedge m.pclk or negedge m.presetn) begin
      if (!m.presetn) begin
         lch_r <= 10'h000;
         mode_r <= xrm_pkg::XRM_MODE_MIF;
         off_r <= 32'h0000_0000;
         data_r <= 32'h0000_0000;
         busy_r <= 1'b0;
         op_r <= 2'h0;
         cnt_r <= 4'h0;
         mif_idx_r <= 2'h0;
         for (int i = 0; i < xrm_pkg::XRM_NIF; i++) begin
            for (int j = 0; j < xrm_pkg::XRM_NXREG; j++) begin
               xreg_r[i][j] <= 32'h0000_0000;
            end
         end
      end else if (busy_r) begin
         if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end else begin
            case (op_r)
               2'h1: begin
                  data_r <= lch_ok ? xreg_r[li][oi] : 32'h0000_0000;
                  busy_r <= 1'b0;
               end
               2'h2: begin
                  if (lch_ok) begin
                     xreg_r[li][4'(mif_idx_r)] <= MIF_WORDS[mif_idx_r];
                  end
                  mif_idx_r <= mif_idx_r + 2'h1;
                  cnt_r <= 4'(xrm_pkg::XRM_BUSY_CYC - 1);
                  busy_r <= (mif_idx_r != 2'(MIF_LEN - 1));
               end
               default: begin
                  if (lch_ok) begin
                     xreg_r[li][oi] <= data_r;
                  end
                  busy_r <= 1'b0;
               end
            endcase
         end
      end else if (wr_take) begin
         case (m.address)
            xrm_pkg::XRM_A_LCH: lch_r <= m.writedata[9:0];
            xrm_pkg::XRM_A_SCTL: mode_r <= m.writedata[1:0];
            xrm_pkg::XRM_A_OFF: off_r <= m.writedata;
            xrm_pkg::XRM_A_DATA: data_r <= m.writedata;
            xrm_pkg::XRM_A_CSR: begin
               cnt_r <= 4'(xrm_pkg::XRM_BUSY_CYC - 1);
               mif_idx_r <= 2'h0;
               if (mode_r == xrm_pkg::XRM_MODE_MAN) begin
                  busy_r <= m.writedata[xrm_pkg::XRM_CSR_WR] | m.writedata[xrm_pkg::XRM_CSR_RD];
                  op_r <= m.writedata[xrm_pkg::XRM_CSR_RD] ? 2'h1 : 2'h0;
               end else if (mode_r == xrm_pkg::XRM_MODE_MIF) begin
                  busy_r <= m.writedata[xrm_pkg::XRM_CSR_WR];
                  op_r <= 2'h2;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge m.pclk or negedge m.presetn) begin
      if (!m.presetn) begin
         peek_data <= 32'h0000_0000;
      end else begin
         peek_data <= (peek_lch < 3'(xrm_pkg::XRM_NIF)) ? xreg_r[peek_lch][peek_off] : 32'h0000_0000;
      end
   end
endmodule : xrm_ctrl
`default_nettype wire

// File: xrm_mgr.sv
// Reconfiguration manager end: request router, read-modify-write sequencer and APB registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Partial updates read then write, others kept
// - Program channel and streamer mode first
// - Controller manual mode writes registers directly
// - Controller mode zero streams stored images
// - Read starts by loading offset register
// - Read launched by control bit one
// - Read data taken after busy clears
// - Write loads offset, data, sets bit zero
// - Write counts done only after busy clears
// - Clock switching touches only transmit side
// - State machine picks bits, writes manual mode
// - Request/acknowledge handshake with video instances
// - Read value held locally, bits replaced
// - One register at a time, repeated
// - One controller per manager
// - Interface counts: duplex two, rx one, tx two
// - Duplex receiver channel zero, receiver two
// - Many instances merged onto one bus
// - Every signal forwarded to its destination
// - Reset clears controller and manager together
// - One clock for controller and manager
module xrm_mgr (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Video instance handshakes
   input wire logic [2:0] recfg_req,
   input wire logic [2:0] recfg_sel,
   output logic [2:0] recfg_done,
   // Controller link
   xrm_mgmt_if.mgr m
);
   // ===========================================================
   // Declarations
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_PRE = 4'h1, S_PRECHK = 4'h2, S_LCH = 4'h3,
      S_MODE = 4'h4, S_OFF = 4'h5, S_RDGO = 4'h6, S_RDPOLL = 4'h7,
      S_RDCHK = 4'h8, S_RDDATA = 4'h9, S_MERGE = 4'hA, S_DATA = 4'hB,
      S_WRGO = 4'hC, S_WRPOLL = 4'hD, S_WRCHK = 4'hE, S_DONE = 4'hF
   } xrm_state_e;
   xrm_state_e state_r;
   logic act_r;
   logic rd_r;
   logic wr_r;
   logic [6:0] addr_r;
   logic [31:0] wdata_r;
   logic [31:0] rdval_r;
   logic [31:0] merged_r;
   logic [1:0] cur_r;
   logic step_r;
   logic sel_r;
   logic [2:0] pend_r;
   logic [2:0] req_d_r;
   logic [2:0] sw_start;
   logic ctrl_en_r;
   logic [15:0] donecnt_r;
   logic done_now;
   logic apb_wr;
   logic mapped;
   logic [31:0] status;

   function automatic logic [1:0] xrm_pick(input logic [2:0] p);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = xrm_pkg::XRM_NREQ - 1; i >= 0; i--) begin
         if (p[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction : xrm_pick

   // ===========================================================
   // Controller link outputs
   // single controller link
   assign m.address = addr_r;
   assign m.read = rd_r;
   assign m.write = wr_r;
   assign m.writedata = wdata_r;
   assign done_now = (state_r == S_DONE) && !act_r;

   // ===========================================================
   // Sequencer
   // one clock, one reset for the whole path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         act_r <= 1'b0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 7'h00;
         wdata_r <= 32'h0000_0000;
         rdval_r <= 32'h0000_0000;
         merged_r <= 32'h0000_0000;
         cur_r <= 2'h0;
         step_r <= 1'b0;
         sel_r <= 1'b0;
      end else if (act_r) begin
         // A link request is held until the controller drops waitrequest.
         if (!m.waitrequest) begin
            act_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            if (rd_r) begin
               rdval_r <= m.readdata;
            end
         end
      end else begin
         case (state_r)
            S_IDLE: begin
               if (ctrl_en_r && (pend_r != 3'h0)) begin
                  cur_r <= xrm_pick(pend_r);
                  sel_r <= recfg_sel[xrm_pick(pend_r)];
                  step_r <= 1'b0;
                  state_r <= S_PRE;
               end
            end
            S_PRE: begin
               act_r <= 1'b1;
               rd_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_CSR;
               state_r <= S_PRECHK;
            end
            S_PRECHK: begin
               state_r <= rdval_r[xrm_pkg::XRM_CSR_BUSY] ? S_PRE : S_LCH;
            end
            S_LCH: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_LCH;
               wdata_r <= {22'h0, xrm_pkg::XRM_REQ_LCN[cur_r]};
               state_r <= S_MODE;
            end
            S_MODE: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_SCTL;
               wdata_r <= {30'h0, xrm_pkg::XRM_MODE_MAN};
               state_r <= S_OFF;
            end
            S_OFF: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_OFF;
               wdata_r <= xrm_pkg::XRM_STEP_OFF[cur_r][step_r];
               state_r <= S_RDGO;
            end
            S_RDGO: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_CSR;
               wdata_r <= 32'h0000_0001 << xrm_pkg::XRM_CSR_RD;
               state_r <= S_RDPOLL;
            end
            S_RDPOLL: begin
               act_r <= 1'b1;
               rd_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_CSR;
               state_r <= S_RDCHK;
            end
            // data read only once busy is clear
            S_RDCHK: begin
               if (rdval_r[xrm_pkg::XRM_CSR_BUSY]) begin
                  state_r <= S_RDPOLL;
               end else begin
                  act_r <= 1'b1;
                  rd_r <= 1'b1;
                  addr_r <= xrm_pkg::XRM_A_DATA;
                  state_r <= S_RDDATA;
               end
            end
            S_RDDATA: begin
               merged_r <= (rdval_r & ~xrm_pkg::XRM_STEP_MASK[cur_r][step_r]) |
                  ((sel_r ? xrm_pkg::XRM_STEP_VAL1[cur_r][step_r] :
                  xrm_pkg::XRM_STEP_VAL0[cur_r][step_r]) & xrm_pkg::XRM_STEP_MASK[cur_r][step_r]);
               state_r <= S_MERGE;
            end
            // offset, then data, then bit zero
            S_MERGE: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_OFF;
               wdata_r <= xrm_pkg::XRM_STEP_OFF[cur_r][step_r];
               state_r <= S_DATA;
            end
            S_DATA: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_DATA;
               wdata_r <= merged_r;
               state_r <= S_WRGO;
            end
            S_WRGO: begin
               act_r <= 1'b1;
               wr_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_CSR;
               wdata_r <= 32'h0000_0001 << xrm_pkg::XRM_CSR_WR;
               state_r <= S_WRPOLL;
            end
            S_WRPOLL: begin
               act_r <= 1'b1;
               rd_r <= 1'b1;
               addr_r <= xrm_pkg::XRM_A_CSR;
               state_r <= S_WRCHK;
            end
            // success only after busy clears; next register
            S_WRCHK: begin
               if (rdval_r[xrm_pkg::XRM_CSR_BUSY]) begin
                  state_r <= S_WRPOLL;
               end else if (step_r == 1'(xrm_pkg::XRM_NSTEP - 1)) begin
                  state_r <= S_DONE;
               end else begin
                  step_r <= step_r + 1'b1;
                  state_r <= S_PRE;
               end
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ===========================================================
   // Request router
   // latch requests, return acknowledge pulses
   genvar g;
   generate
      for (g = 0; g < xrm_pkg::XRM_NREQ; g++) begin : g_req
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               req_d_r[g] <= 1'b0;
               pend_r[g] <= 1'b0;
               recfg_done[g] <= 1'b0;
            end else begin
               req_d_r[g] <= recfg_req[g];
               // A new request in the cycle its predecessor finishes is kept.
               pend_r[g] <= (recfg_req[g] & ~req_d_r[g]) | sw_start[g] |
                  (pend_r[g] & ~(done_now && (cur_r == 2'(g))));
               recfg_done[g] <= done_now && (cur_r == 2'(g));
            end
         end
      end
   endgenerate

   // ===========================================================
   // APB registers
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   assign mapped = (paddr == xrm_pkg::XRM_R_CTRL) || (paddr == xrm_pkg::XRM_R_STATUS) ||
      (paddr == xrm_pkg::XRM_R_LASTWR) || (paddr == xrm_pkg::XRM_R_DONECNT);
   assign pslverr = psel & penable & ~mapped;
   assign sw_start = (apb_wr && (paddr == xrm_pkg::XRM_R_CTRL)) ?
      pwdata[xrm_pkg::XRM_CTRL_SW_LSB +: 3] : 3'h0;

   always_comb begin
      status = 32'h0000_0000;
      status[xrm_pkg::XRM_ST_BUSY_BIT] = (state_r != S_IDLE);
      status[xrm_pkg::XRM_ST_PEND_LSB +: 3] = pend_r;
      status[xrm_pkg::XRM_ST_STATE_LSB +: 4] = state_r;
      status[xrm_pkg::XRM_ST_CUR_LSB +: 2] = cur_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_r <= xrm_pkg::XRM_CTRL_EN_RST;
         donecnt_r <= 16'h0000;
      end else begin
         if (apb_wr && (paddr == xrm_pkg::XRM_R_CTRL)) begin
            ctrl_en_r <= pwdata[xrm_pkg::XRM_CTRL_EN_BIT];
         end
         if (done_now) begin
            donecnt_r <= donecnt_r + 16'h0001;
         end
      end
   end

   // Read data is captured in the setup cycle so that the access cycle needs no wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            xrm_pkg::XRM_R_CTRL: prdata <= 32'(ctrl_en_r) << xrm_pkg::XRM_CTRL_EN_BIT;
            xrm_pkg::XRM_R_STATUS: prdata <= status;
            xrm_pkg::XRM_R_LASTWR: prdata <= merged_r;
            xrm_pkg::XRM_R_DONECNT: prdata <= {16'h0000, donecnt_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : xrm_mgr
`default_nettype wire

// File: xrm_link_props.sv
// Property checker for the management link between manager and controller.
`timescale 1ns/1ps
`default_nettype none
module xrm_link_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link signals
   input wire logic [6:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   logic acc;
   logic w_csr;
   logic busy_r;
   logic mode_r;
   logic off_r;
   logic dat_r;
   assign acc = (read | write) & ~waitrequest;
   assign w_csr = write && address == xrm_pkg::XRM_A_CSR;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========
   // Busy is only known to be clear once a status read has shown it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
      end else if (acc && w_csr) begin
         busy_r <= 1'b1;
      end else if (acc && read && address == xrm_pkg::XRM_A_CSR &&
         !readdata[xrm_pkg::XRM_CSR_BUSY]) begin
         busy_r <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 1'b0;
         off_r <= 1'b0;
         dat_r <= 1'b0;
      end else if (acc) begin
         if (write && address == xrm_pkg::XRM_A_SCTL) mode_r <= writedata[1:0] == 2'h1;
         if (write && address == xrm_pkg::XRM_A_OFF) off_r <= 1'b1;
         else if (w_csr) off_r <= 1'b0;
         if (write && address == xrm_pkg::XRM_A_DATA) dat_r <= 1'b1;
         else if (w_csr) dat_r <= 1'b0;
      end
   end
   // ========
   // Link assertions
   a_req_held: assert property ((read | write) && waitrequest |=>
      $stable({address, read, write, writedata})) else $error("request changed while waiting");
   a_drop_after: assert property (acc |=> !(read | write))
      else $error("request held after acceptance");
   a_single_op: assert property (!(read && write))
      else $error("read and write together");
   a_ctrl_answer: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
      else $error("controller answer not after one wait cycle");
   a_mode_manual: assert property (write && address == xrm_pkg::XRM_A_SCTL |->
      writedata[1:0] == 2'h1) else $error("streamer mode not manual");
   a_mode_first: assert property (write && address == xrm_pkg::XRM_A_OFF |-> mode_r)
      else $error("offset before mode set");
   a_read_start: assert property (w_csr && writedata[1] |-> off_r && !writedata[0])
      else $error("read launched without offset");
   a_write_start: assert property (w_csr && writedata[0] |-> off_r && dat_r)
      else $error("write launched without offset and data");
   a_data_after_busy: assert property (read && address == xrm_pkg::XRM_A_DATA |-> !busy_r)
      else $error("data read before busy cleared");
   a_idle_while_busy: assert property (write |-> !busy_r)
      else $error("write issued while busy");
   c_read_launch: cover property (acc && w_csr && writedata[1]);
   c_write_launch: cover property (acc && w_csr && writedata[0]);
   c_busy_seen: cover property (acc && read && address == xrm_pkg::XRM_A_CSR &&
      readdata[xrm_pkg::XRM_CSR_BUSY]);
endmodule : xrm_link_props
`default_nettype wire

// File: xcvr_reconfig_rmw_manager_test.sv
// Self-checking bench joining the manager and the controller over the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module xcvr_reconfig_rmw_manager_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xcvr_busy, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, peek_data, q, ex, side;
   logic [31:0] pre [2];
   logic [2:0] recfg_req, recfg_sel, recfg_done, peek_lch;
   logic [3:0] peek_off;
   int n_errors, cmp_count, i;
   int ri [4] = '{0, 1, 2, 2};
   logic rs [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   xrm_mgmt_if u_xrm_mgmt_if (.pclk(pclk), .presetn(presetn));
   xrm_mgr u_xrm_mgr (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .recfg_req(recfg_req), .recfg_sel(recfg_sel),
      .recfg_done(recfg_done), .m(u_xrm_mgmt_if));
   xrm_ctrl u_xrm_ctrl (.m(u_xrm_mgmt_if), .xcvr_busy(xcvr_busy), .peek_lch(peek_lch),
      .peek_off(peek_off), .peek_data(peek_data));
   xrm_link_props u_xrm_link_props (.pclk(pclk), .presetn(presetn),
      .address(u_xrm_mgmt_if.address), .read(u_xrm_mgmt_if.read),
      .write(u_xrm_mgmt_if.write), .writedata(u_xrm_mgmt_if.writedata),
      .readdata(u_xrm_mgmt_if.readdata), .waitrequest(u_xrm_mgmt_if.waitrequest));
   always #4 pclk = ~pclk;
   // ========
   // Bus tasks
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 99) begin
         n++;
         @(posedge pclk);
      end
      `CHK("pready", 1'b1, pready)
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic peek(input logic [2:0] l, input int r, input int k);
      peek_lch <= l;
      peek_off <= xrm_pkg::XRM_STEP_OFF[r][k][3:0];
      repeat (2) @(posedge pclk);
      q = peek_data;
   endtask : peek
   task automatic wait_done(input int r);
      int n;
      n = 0;
      while (recfg_done[r] !== 1'b1 && n < 2000) begin
         n++;
         @(posedge pclk);
      end
      `CHK("done", 1'b1, recfg_done[r])
   endtask : wait_done
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // ========
   // Test sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {recfg_req, recfg_sel, peek_lch, peek_off} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(xrm_pkg::XRM_R_CTRL, 1'b0, 32'h0);
      `CHK("ctrl", 4'h1, q[3:0])
      apb(xrm_pkg::XRM_R_STATUS, 1'b0, 32'h0);
      `CHK("pending", 3'h0, q[6:4])
      `CHK("seq idle", 1'b0, q[0])
      apb(12'h010, 1'b0, 32'h0);
      `CHK("pslverr", 1'b1, e)
      `CHK("unmapped", 32'h0000_0000, q)
      $display("test reset done");
      for (int t = 0; t < 4; t++) begin
         i = ri[t];
         for (int k = 0; k < 2; k++) begin
            peek(xrm_pkg::XRM_REQ_LCN[i][2:0], i, k);
            pre[k] = q;
         end
         peek(xrm_pkg::XRM_LCN_RX[2:0], 2, 0);
         side = q;
         recfg_sel[i] <= rs[t];
         recfg_req[i] <= 1'b1;
         wait_done(i);
         recfg_req[i] <= 1'b0;
         `CHK("xcvr busy", 1'b0, xcvr_busy)
         for (int k = 0; k < 2; k++) begin
            ex = rs[t] ? xrm_pkg::XRM_STEP_VAL1[i][k] : xrm_pkg::XRM_STEP_VAL0[i][k];
            ex = (pre[k] & ~xrm_pkg::XRM_STEP_MASK[i][k]) | ex;
            peek(xrm_pkg::XRM_REQ_LCN[i][2:0], i, k);
            `CHK("store", ex, q)
         end
         apb(xrm_pkg::XRM_R_LASTWR, 1'b0, 32'h0);
         `CHK("lastwr", ex, q)
         peek(xrm_pkg::XRM_LCN_RX[2:0], 2, 0);
         `CHK("rx side untouched", side, q)
      end
      apb(xrm_pkg::XRM_R_DONECNT, 1'b0, 32'h0);
      `CHK("donecnt", 16'h0004, q[15:0])
      $display("test rmw done");
      // Requests raised while disabled must wait, so all three show pending.
      apb(xrm_pkg::XRM_R_CTRL, 1'b1, 32'hE);
      apb(xrm_pkg::XRM_R_STATUS, 1'b0, 32'h0);
      `CHK("pending", 3'h7, q[6:4])
      apb(xrm_pkg::XRM_R_CTRL, 1'b1, 32'h1);
      for (int n = 0; n < 300 && q[15:0] !== 16'h0007; n++) begin
         apb(xrm_pkg::XRM_R_DONECNT, 1'b0, 32'h0);
      end
      `CHK("donecnt", 16'h0007, q[15:0])
      apb(xrm_pkg::XRM_R_STATUS, 1'b0, 32'h0);
      `CHK("pending", 3'h0, q[6:4])
      $display("test queue done");
      give_verdict();
   end
   // The whole run needs under a thousand cycles; this margin only catches a hang.
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end
endmodule : xcvr_reconfig_rmw_manager_test
`default_nettype wire
